// ---- design/sac_adc_ctrl.sv ----
// Control logic of a 10-bit successive-approximation converter
`timescale 1ns/1ps
// Behaviour
// - Codes 0-15 route pins, 16-21 ground, reserved codes flag undefined.
// - 29 high ref, 30 low ref, 28 reserved, 31 turns converter off.
// - 26 connects temperature sensor, 27 bandgap reference.
// - Conversion clock from bus, bus half, local async or alternate.
// - Alternate clock input is the external reference clock output.
// - Selected source divided by the divide select field.
// - Alternate clock usable in wait, never in stop.
// - Enabled hardware trigger starts a conversion on counter overflow.
// - Trigger works regardless of the counter's interrupt enable.
// - Trigger path works in run, wait and stop3.
// - Ten-bit linear successive approximation per sample.
// - Result right-justified in 10-bit or 8-bit form.
// - Single and continuous modes; single returns to idle.
// - Optional compare, less-than or greater-equal, may raise interrupt.
// - Conversion-complete flag with enabled interrupt request.
// - Control write aborts; restarts only if trigger disabled and channel not all ones.
// - Flag clears on control write or low read; compare gates set.
// - Continuous keeps converting after a start; else one per start.
// - All-ones channel powers off, stops continuous, no extra conversion.
module sac_adc_ctrl
  import sac_pkg::*;
#(
  parameter int SAMPLE_LEN = SAMPLE_TICKS
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control register write and its fields
  input wire logic ctrlWrite,
  input wire logic [4:0] channelSelect,
  input wire logic continuousModeEnable,
  input wire logic convIrqEnable,
  input wire logic hwTriggerEnable,
  input wire logic compareFunctionEnable,
  input wire logic compareGreaterEqual,
  input wire logic [9:0] compareValue,
  input wire logic mode8Bit,
  input wire logic resultLowByteRead,
  // Clock configuration and power modes
  input wire logic [1:0] clockSelect,
  input wire logic [1:0] clockDivideSelect,
  input wire logic localAsyncConvClock,
  input wire logic extReferenceClockOut,
  input wire logic stopMode,
  // Trigger and analog front end
  input wire logic hwTriggerInput,
  input wire logic comparatorHigh,
  // Front end control
  output logic [2:0] sourceKind,
  output logic [3:0] pinSelect,
  output logic converterPowered,
  output logic sampleEnable,
  output logic [9:0] trialCode,
  // Status
  output logic [9:0] result,
  output logic resultUndefined,
  output logic conversionDoneFlag,
  output logic convIrq,
  output logic convActive
);
  // ==========================================================
  // Channel decode
  function automatic sac_src_t decodeChannel(input logic [4:0] ch);
    if (ch <= CH_PIN_LAST)
      return SRC_PIN;
    if (ch >= CH_GND_FIRST && ch <= CH_GND_LAST)
      return SRC_GND;
    if (ch == CH_TEMP)
      return SRC_TEMP;
    if (ch == CH_BANDGAP)
      return SRC_BANDGAP;
    if (ch == CH_REFH)
      return SRC_REFH;
    if (ch == CH_REFL)
      return SRC_REFL;
    if (ch == CH_OFF)
      return SRC_OFF;
    return SRC_RESERVED;
  endfunction

  sac_state_t stateReg;
  logic convTick;
  logic trigSync1, trigSync2, trigSync3;
  logic trigEvent, swStart, startConv, lastBit, done;
  logic contReg, chanReservedReg;
  logic [3:0] bitIdxReg;
  logic [3:0] sampleCntReg;
  logic [9:0] sarValue, finalCode, formatted;
  logic cmpTrue;

  // ==========================================================
  // Conversion clock
  // alternate input is external reference clock
  sac_clk_div u_clk_div (
    .clock(clock),
    .rst(rst),
    .clockSelect(clockSelect),
    .clockDivideSelect(clockDivideSelect),
    .localAsyncTick(localAsyncConvClock),
    .altClockTick(extReferenceClockOut),
    .stopMode(stopMode),
    .convTick(convTick)
  );

  // ==========================================================
  // Hardware trigger; no mode or counter irq gating here
  // two-flop synchroniser and edge
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      trigSync1 <= 1'b0;
      trigSync2 <= 1'b0;
      trigSync3 <= 1'b0;
    end
    else
    begin
      trigSync1 <= hwTriggerInput;
      trigSync2 <= trigSync1;
      trigSync3 <= trigSync2;
    end

  assign trigEvent = hwTriggerEnable & trigSync2 & ~trigSync3
                     & (stateReg == ST_IDLE)
                     & (channelSelect != CH_OFF);
  assign swStart = ctrlWrite & (channelSelect != CH_OFF)
                   & ~hwTriggerEnable;
  assign startConv = swStart | (trigEvent & ~ctrlWrite);
  assign lastBit = (stateReg == ST_CONVERT) && convTick
                   && bitIdxReg == 4'h0;
  assign done = lastBit & ~ctrlWrite;

  // ==========================================================
  // Sequencer
  // one bit per conversion clock, MSB first
  always_comb
  begin
    sarValue = trialCode;
    if (!comparatorHigh)
      sarValue[bitIdxReg] = 1'b0;
    finalCode = sarValue;
  end

  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      stateReg <= ST_IDLE;
      bitIdxReg <= 4'h0;
      sampleCntReg <= 4'h0;
      trialCode <= RESULT_RESET;
      sampleEnable <= 1'b0;
    end
    else if (ctrlWrite && !swStart)
    begin
      stateReg <= ST_IDLE;
      sampleEnable <= 1'b0;
    end
    else if (startConv || (done && contReg))
    begin
      stateReg <= ST_SAMPLE;
      sampleCntReg <= 4'(SAMPLE_LEN - 1);
      sampleEnable <= 1'b1;
    end
    else
    begin
      case (stateReg)
        ST_IDLE: sampleEnable <= 1'b0;
        ST_SAMPLE:
          if (convTick)
          begin
            if (sampleCntReg == 4'h0)
            begin
              stateReg <= ST_CONVERT;
              sampleEnable <= 1'b0;
              bitIdxReg <= 4'(RESULT_BITS - 1);
              trialCode <= 10'h200;
            end
            else
              sampleCntReg <= sampleCntReg - 4'h1;
          end
        ST_CONVERT:
          if (convTick)
          begin
            if (bitIdxReg == 4'h0)
              stateReg <= ST_IDLE;
            else
            begin
              trialCode <= sarValue | (10'h001 << (bitIdxReg - 4'h1));
              bitIdxReg <= bitIdxReg - 4'h1;
            end
          end
        default: stateReg <= ST_IDLE;
      endcase
    end

  // ==========================================================
  // Mode and channel capture
  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      contReg <= 1'b0;
      sourceKind <= SRC_OFF;
      pinSelect <= 4'h0;
      converterPowered <= 1'b0;
      chanReservedReg <= 1'b0;
    end
    else if (ctrlWrite)
    begin
      contReg <= continuousModeEnable && channelSelect != CH_OFF;
      sourceKind <= decodeChannel(channelSelect);
      pinSelect <= channelSelect[3:0];
      converterPowered <= channelSelect != CH_OFF;
      chanReservedReg <= decodeChannel(channelSelect) == SRC_RESERVED;
    end

  // ==========================================================
  // Result, compare and flag
  // right-justified 10 or 8 bits
  assign formatted = mode8Bit ? {2'b00, finalCode[9:2]} : finalCode;
  assign cmpTrue = compareGreaterEqual ? (formatted >= compareValue)
                                       : (formatted < compareValue);

  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      result <= RESULT_RESET;
      resultUndefined <= 1'b0;
      conversionDoneFlag <= 1'b0;
      convIrq <= 1'b0;
      convActive <= 1'b0;
    end
    else
    begin
      convActive <= startConv || (done && contReg)
                    || (stateReg != ST_IDLE && !done
                        && !(ctrlWrite && !swStart));
      // compare gates the set; set beats a read
      if (done && (!compareFunctionEnable || cmpTrue))
      begin
        result <= formatted;
        resultUndefined <= chanReservedReg;
        conversionDoneFlag <= 1'b1;
        convIrq <= convIrqEnable;
      end
      else if (ctrlWrite || resultLowByteRead)
      begin
        conversionDoneFlag <= 1'b0;
        convIrq <= 1'b0;
      end
      else
        convIrq <= conversionDoneFlag & convIrqEnable;
    end

  // ==========================================================
  // Checks
  sequence s_trig_edge;
    hwTriggerEnable && stateReg == ST_IDLE && !ctrlWrite
    && channelSelect != CH_OFF && trigSync2 && !trigSync3;
  endsequence
  sequence s_sampling;
    stateReg == ST_SAMPLE;
  endsequence

  property p_trig_start;
    @(posedge clock) disable iff (rst) s_trig_edge |=> s_sampling;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger edge did not start sampling");

  property p_busy_ignore;
    @(posedge clock) disable iff (rst)
      (stateReg == ST_CONVERT && !ctrlWrite && !lastBit)
      |=> stateReg != ST_SAMPLE;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("conversion restarted while busy");

  property p_write_start;
    @(posedge clock) disable iff (rst)
      (ctrlWrite && !hwTriggerEnable && channelSelect != CH_OFF)
      |=> stateReg == ST_SAMPLE && sampleEnable;
  endproperty
  a_write_start: assert property (p_write_start)
    else $error("control write did not restart");

  property p_off_stop;
    @(posedge clock) disable iff (rst)
      (ctrlWrite && channelSelect == CH_OFF)
      |=> stateReg == ST_IDLE && !converterPowered && !contReg;
  endproperty
  a_off_stop: assert property (p_off_stop)
    else $error("off code left converter running");

  property p_single_idle;
    @(posedge clock) disable iff (rst)
      (done && !contReg && !startConv) |=> stateReg == ST_IDLE;
  endproperty
  a_single_idle: assert property (p_single_idle)
    else $error("single conversion did not return to idle");

  property p_cont_again;
    @(posedge clock) disable iff (rst)
      (done && contReg) |=> s_sampling;
  endproperty
  a_cont_again: assert property (p_cont_again)
    else $error("continuous mode did not restart");

  property p_flag_clear;
    @(posedge clock) disable iff (rst)
      (ctrlWrite && !done) |=> !conversionDoneFlag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag survived a control write");

  property p_cmp_gate;
    @(posedge clock) disable iff (rst)
      (done && compareFunctionEnable && !cmpTrue && !conversionDoneFlag)
      |=> !conversionDoneFlag;
  endproperty
  a_cmp_gate: assert property (p_cmp_gate)
    else $error("flag set though compare failed");

  property p_irq;
    @(posedge clock) disable iff (rst)
      (conversionDoneFlag && convIrqEnable && $stable(convIrqEnable)
       && !ctrlWrite && !resultLowByteRead) |=> ##1 convIrq || !convIrqEnable
      || !conversionDoneFlag;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled flag gave no interrupt");

  property p_fmt8;
    @(posedge clock) disable iff (rst)
      (done && mode8Bit && !compareFunctionEnable)
      |=> result[9:8] == 2'b00;
  endproperty
  a_fmt8: assert property (p_fmt8)
    else $error("8-bit result not right-justified");

  property p_sar_len;
    @(posedge clock) disable iff (rst)
      $rose(stateReg == ST_CONVERT) |-> bitIdxReg == 4'd9;
  endproperty
  a_sar_len: assert property (p_sar_len)
    else $error("conversion did not start at bit 9");

  property p_reserved;
    @(posedge clock) disable iff (rst)
      (ctrlWrite && channelSelect == 5'h1c) |=> sourceKind == SRC_RESERVED;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved code not decoded as reserved");
endmodule // sac_adc_ctrl

// ---- include/sac_pkg.sv ----
// Shared constants and types for the SAR converter control block
package sac_pkg;
  // ==========================================================
  // Channel select codes
  localparam logic [4:0] CH_PIN_LAST = 5'h0f;
  localparam logic [4:0] CH_GND_FIRST = 5'h10;
  localparam logic [4:0] CH_GND_LAST = 5'h15;
  localparam logic [4:0] CH_TEMP = 5'h1a;
  localparam logic [4:0] CH_BANDGAP = 5'h1b;
  localparam logic [4:0] CH_REFH = 5'h1d;
  localparam logic [4:0] CH_REFL = 5'h1e;
  localparam logic [4:0] CH_OFF = 5'h1f;
  // ==========================================================
  // Clock sources and timing
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_LOCAL = 2'h3;
  localparam int SAMPLE_TICKS = 4;
  localparam int RESULT_BITS = 10;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SRC_PIN = 3'b000, SRC_GND = 3'b001, SRC_TEMP = 3'b010,
    SRC_BANDGAP = 3'b011, SRC_REFH = 3'b100, SRC_REFL = 3'b101,
    SRC_RESERVED = 3'b110, SRC_OFF = 3'b111
  } sac_src_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_SAMPLE = 2'b01, ST_CONVERT = 2'b10
  } sac_state_t;
endpackage

// ---- design/sac_clk_div.sv ----
// Conversion clock source select and divider producing an enable pulse
`timescale 1ns/1ps
module sac_clk_div
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Source selection
  input wire logic [1:0] clockSelect,
  input wire logic [1:0] clockDivideSelect,
  input wire logic localAsyncTick,
  input wire logic altClockTick,
  input wire logic stopMode,
  // Conversion clock enable
  output logic convTick
);
  logic halfReg;
  logic [2:0] divCountReg;
  logic srcTick;
  logic [2:0] divLast;

  always_ff @(posedge clock or posedge rst)
    if (rst)
      halfReg <= 1'b0;
    else
      halfReg <= ~halfReg;

  always_comb
  begin
    case (clockSelect)
      CLK_BUS: srcTick = 1'b1;
      CLK_BUS_HALF: srcTick = halfReg;
      CLK_ALT: srcTick = altClockTick & ~stopMode;
      CLK_LOCAL: srcTick = localAsyncTick;
      default: srcTick = 1'b0;
    endcase
  end

  // divide by 1, 2, 4 or 8
  assign divLast = 3'((4'd1 << clockDivideSelect) - 4'd1);

  always_ff @(posedge clock or posedge rst)
    if (rst)
    begin
      divCountReg <= 3'h0;
      convTick <= 1'b0;
    end
    else
    begin
      convTick <= 1'b0;
      if (srcTick)
      begin
        if (divCountReg >= divLast)
        begin
          divCountReg <= 3'h0;
          convTick <= 1'b1;
        end
        else
          divCountReg <= divCountReg + 3'h1;
      end
    end

  property p_div_bus;
    @(posedge clock) disable iff (rst)
      (clockSelect == CLK_BUS && clockDivideSelect == 2'h0
       && $stable(clockSelect)) |=> convTick;
  endproperty
  a_div_bus: assert property (p_div_bus)
    else $error("undivided bus clock gave no tick");

  property p_alt_stop;
    @(posedge clock) disable iff (rst)
      (clockSelect == CLK_ALT && stopMode && $past(stopMode)
       && $past(clockSelect) == CLK_ALT) |-> !convTick;
  endproperty
  a_alt_stop: assert property (p_alt_stop)
    else $error("alternate clock ticked in stop");
endmodule // sac_clk_div

// ---- bench/sac_front_model.sv ----
// Analog front end and counter trigger model for the converter bench
`timescale 1ns/1ps
module sac_front_model
  import sac_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Converter side
  input wire logic [2:0] sourceKind,
  input wire logic [3:0] pinSelect,
  input wire logic [9:0] trialCode,
  output logic comparatorHigh,
  // Counter side
  input wire logic rtcOverflow,
  output logic hwTriggerInput
);
  logic [9:0] level;
  logic [1:0] holdCount_reg;
  // ==========================================================
  // Input levels, one distinct value per pin
  always_comb
  begin
    case (sourceKind)
      SRC_PIN: level = {pinSelect, 6'h25};
      SRC_TEMP: level = 10'h155;
      // level assumes software enabled the bandgap buffer
      SRC_BANDGAP: level = 10'h0c8;
      SRC_REFH: level = 10'h3ff;
      default: level = 10'h000;
    endcase
  end
  assign comparatorHigh = level >= trialCode;
  // ==========================================================
  // Overflow output, held two clocks so it is never missed
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      holdCount_reg <= 2'h0;
    else if (rtcOverflow)
      holdCount_reg <= 2'h2;
    else if (holdCount_reg != 2'h0)
      holdCount_reg <= holdCount_reg - 2'h1;
  end
  assign hwTriggerInput = holdCount_reg != 2'h0;
endmodule // sac_front_model

// ---- bench/sar_adc_channel_clock_trigger_bench.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module sar_adc_channel_clock_trigger_bench
  import sac_pkg::*;
;
  logic clock, rst, ctrlWrite, continuousModeEnable, convIrqEnable;
  logic hwTriggerEnable, compareFunctionEnable, compareGreaterEqual;
  logic [4:0] channelSelect;
  logic [9:0] compareValue, trialCode, result;
  logic mode8Bit, resultLowByteRead, localAsyncConvClock, rtcOverflow;
  logic extReferenceClockOut, stopMode, hwTriggerInput, comparatorHigh;
  logic [1:0] clockSelect, clockDivideSelect;
  logic [2:0] sourceKind;
  logic [3:0] pinSelect;
  logic converterPowered, sampleEnable, resultUndefined;
  logic conversionDoneFlag, convIrq, convActive;
  int n_errors, check_count, cycleCount, tickPhase;
  bit got;

  sac_adc_ctrl u_sac_adc_ctrl (.clock, .rst, .ctrlWrite, .channelSelect,
    .continuousModeEnable, .convIrqEnable, .hwTriggerEnable,
    .compareFunctionEnable, .compareGreaterEqual, .compareValue, .mode8Bit,
    .resultLowByteRead, .clockSelect, .clockDivideSelect,
    .localAsyncConvClock, .extReferenceClockOut, .stopMode, .hwTriggerInput,
    .comparatorHigh, .sourceKind, .pinSelect, .converterPowered,
    .sampleEnable, .trialCode, .result, .resultUndefined,
    .conversionDoneFlag, .convIrq, .convActive);
  sac_front_model u_sac_front_model (.clock, .rst, .sourceKind, .pinSelect,
    .trialCode, .comparatorHigh, .rtcOverflow, .hwTriggerInput);

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ==========================================================
  // Slow source ticks and hang guard
  always @(posedge clock)
  begin
    #1;
    cycleCount++;
    tickPhase = (tickPhase + 1) % 15;
    localAsyncConvClock = tickPhase % 3 == 0;
    extReferenceClockOut = tickPhase % 5 == 0;
    if (cycleCount == 40000)
    begin
      n_errors++;
      test_done();
    end
  end
  // ==========================================================
  // Helpers
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [9:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clock);
      #1;
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic wait_done(input int lim, output bit seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++)
    begin
      tick(1);
      seen = conversionDoneFlag === 1'b1;
    end
  endtask
  task automatic conv(input logic [4:0] ch, input bit expGot, input int lim);
    channelSelect = ch;
    pulse(ctrlWrite);
    check("flag clear", 10'(conversionDoneFlag), 10'h0);
    wait_done(lim, got);
    check("done", 10'(got), 10'(expGot));
  endtask
  function automatic logic [9:0] lvl(input logic [4:0] ch);
    if (ch <= CH_PIN_LAST)
      return {ch[3:0], 6'h25};
    if (ch == CH_TEMP)
      return 10'h155;
    if (ch == CH_BANDGAP)
      return 10'h0c8;
    return ch == CH_REFH ? 10'h3ff : 10'h000;
  endfunction
  function automatic logic [2:0] kindOf(input logic [4:0] ch);
    case (ch) inside
      [5'h00:CH_PIN_LAST]: return 3'h0;
      [CH_GND_FIRST:CH_GND_LAST]: return 3'h1;
      CH_TEMP: return 3'h2;
      CH_BANDGAP: return 3'h3;
      CH_REFH: return 3'h4;
      CH_REFL: return 3'h5;
      CH_OFF: return 3'h7;
      default: return 3'h6;
    endcase
  endfunction
  // ==========================================================
  // Scenarios
  task automatic sc_channels();
    check("reset kind", 10'(sourceKind), 10'(SRC_OFF));
    check("reset result", result, RESULT_RESET);
    for (int c = 0; c < 31; c++)
    begin
      conv(5'(c), 1'b1, 200);
      check("kind", 10'(sourceKind), 10'(kindOf(5'(c))));
      check("pin", 10'(pinSelect), 10'(c[3:0]));
      if (kindOf(5'(c)) == SRC_RESERVED)
        check("undefined", 10'(resultUndefined), 10'h1);
      else
      begin
        check("result", result, lvl(5'(c)));
        check("defined", 10'(resultUndefined), 10'h0);
      end
      tick(1);
      check("idle", 10'(convActive), 10'h0);
    end
  endtask
  task automatic sc_format();
    mode8Bit = 1'b1;
    conv(5'h09, 1'b1, 200);
    check("8-bit", result, lvl(5'h09) >> 2);
    check("irq off", 10'(convIrq), 10'h0);
    mode8Bit = 1'b0;
    conv(CH_BANDGAP, 1'b1, 200);
    check("bandgap", result, lvl(CH_BANDGAP));
    conv(CH_TEMP, 1'b1, 200);
    check("temp", result, lvl(CH_TEMP));
  endtask
  task automatic sc_compare();
    compareFunctionEnable = 1'b1;
    convIrqEnable = 1'b1;
    compareValue = lvl(5'h03) + 10'h1;
    conv(5'h03, 1'b1, 200);
    tick(1);
    check("irq", 10'(convIrq), 10'h1);
    pulse(resultLowByteRead);
    tick(1);
    check("read clear", 10'(conversionDoneFlag), 10'h0);
    check("irq clear", 10'(convIrq), 10'h0);
    compareValue = lvl(5'h03);
    conv(5'h03, 1'b0, 200);
    compareGreaterEqual = 1'b1;
    conv(5'h03, 1'b1, 200);
    {compareFunctionEnable, compareGreaterEqual, convIrqEnable} = 3'h0;
  endtask
  task automatic sc_abort();
    channelSelect = 5'h01;
    pulse(ctrlWrite);
    tick(3);
    check("active", 10'(convActive), 10'h1);
    check("sampling", 10'(sampleEnable), 10'h1);
    conv(5'h0c, 1'b1, 200);
    check("restart", result, lvl(5'h0c));
    pulse(resultLowByteRead);
    wait_done(150, got);
    check("no leftover", 10'(got), 10'h0);
  endtask
  task automatic sc_continuous();
    continuousModeEnable = 1'b1;
    conv(5'h02, 1'b1, 200);
    pulse(resultLowByteRead);
    wait_done(200, got);
    check("repeat", 10'(got), 10'h1);
    conv(CH_OFF, 1'b0, 200);
    check("powered", 10'(converterPowered), 10'h0);
    continuousModeEnable = 1'b0;
  endtask
  task automatic sc_trigger();
    hwTriggerEnable = 1'b1;
    stopMode = 1'b1;
    conv(5'h04, 1'b0, 60);
    pulse(rtcOverflow);
    wait_done(200, got);
    check("hw start", 10'(got), 10'h1);
    check("hw result", result, lvl(5'h04));
    pulse(resultLowByteRead);
    pulse(rtcOverflow);
    tick(8);
    pulse(rtcOverflow);
    wait_done(200, got);
    check("one start", 10'(got), 10'h1);
    pulse(resultLowByteRead);
    wait_done(200, got);
    check("not queued", 10'(got), 10'h0);
    hwTriggerEnable = 1'b0;
    stopMode = 1'b0;
  endtask
  task automatic sc_clocks();
    for (int s = 0; s < 4; s++)
    begin
      clockSelect = 2'(s);
      clockDivideSelect = 2'(3 - s);
      conv(5'h07, 1'b1, 3000);
      check("clocked", result, lvl(5'h07));
    end
    clockSelect = CLK_ALT;
    clockDivideSelect = 2'h0;
    stopMode = 1'b1;
    conv(5'h08, 1'b0, 300);
    stopMode = 1'b0;
    wait_done(300, got);
    check("alt resumes", 10'(got), 10'h1);
    clockSelect = CLK_BUS;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    {ctrlWrite, continuousModeEnable, convIrqEnable, hwTriggerEnable} = 4'h0;
    {compareFunctionEnable, compareGreaterEqual, mode8Bit} = 3'h0;
    {resultLowByteRead, localAsyncConvClock, extReferenceClockOut} = 3'h0;
    {stopMode, rtcOverflow} = 2'h0;
    channelSelect = CH_OFF;
    compareValue = 10'h000;
    clockSelect = CLK_BUS;
    clockDivideSelect = 2'h0;
    rst = 1'b1;
    tick(3);
    rst = 1'b0;
    sc_channels();
    sc_format();
    sc_compare();
    sc_abort();
    sc_continuous();
    sc_trigger();
    sc_clocks();
    test_done();
  end
endmodule // sar_adc_channel_clock_trigger_bench
